//--- verilog/vector_map_pkg.sv
// Notes on behaviour
// (R01) With the boot-reset fuse unprogrammed, every reset starts execution at word address 0x0000.
// (R02) External request zero maps to 0x0002, pin change zero to 0x0004 and pin change one to 0x0006.
// (R03) Timer vectors sit at 0x0008 through 0x0016 in the order timer two, timer one, timer zero.
// (R04) Serial vectors sit at 0x0018 through 0x0022 (transfer, receive, empty, transmit, start, overflow).
// (R05) Comparator, converter, eeprom, program store and display vectors sit at 0x0024 through 0x002c.
// (R06) Pin change two at 0x002e and pin change three at 0x0030 exist only in the larger variant.
// (R07) With the vector-select bit set, each interrupt vector is its base address plus the boot start.
// (R08) With the boot-reset fuse programmed (0), execution starts after reset at the boot reset address.
// (R09) Reset address follows only the fuse, vector start only the select bit; all four pairs work.
// (R10) Software sets the change-enable bit, then within four cycles writes the select with enable zero.
// (R11) Interrupts are blocked from enable set until after the next instruction, or four cycles, I flag untouched.
// (R12) Among several pending enabled requests the lowest vector number is served first.
package vector_map_pkg;
  localparam int          NUM_SRC        = 24;
  localparam logic [15:0] RESET_VECTOR   = 16'h0000;
  localparam logic [15:0] FIRST_VECTOR   = 16'h0002;
  localparam logic [15:0] VECTOR_STRIDE  = 16'h0002;
  localparam logic [15:0] BOOT_START_DEF = 16'h3800;
  localparam int          SMALL_SRC      = 22;
  localparam logic [2:0]  CHANGE_WINDOW  = 3'h4;
  localparam logic [31:0] CTRL_OFFSET    = 32'h0000_0000;
  localparam logic [31:0] STAT_OFFSET    = 32'h0000_0004;
  localparam logic [31:0] MASK_OFFSET    = 32'h0000_0008;
  localparam logic [31:0] VEC_OFFSET     = 32'h0000_000c;
  localparam int          CTRL_CE_BIT    = 0;
  localparam int          CTRL_SEL_BIT   = 1;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
  localparam logic [1:0]  EVT_TIMEOUT    = 2'h1;
  localparam logic [1:0]  EVT_RELOC      = 2'h2;
  localparam int          EVT_W          = 2;
endpackage : vector_map_pkg

//--- verilog/interrupt_vector_mapper.sv
// Added by the designer: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module interrupt_vector_mapper
  import vector_map_pkg::*;
#(
  parameter bit          LARGE_VARIANT = 1'b1,
  parameter logic [15:0] BOOT_START    = BOOT_START_DEF
) (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic               boot_reset_fuse,
  input  wire logic [NUM_SRC-1:0] irq_request,
  input  wire logic               global_int_flag,
  input  wire logic               instr_retire,
  input  wire logic               vector_ack,
  output logic                    vector_valid,
  output logic [15:0]             vector_addr,
  output logic [15:0]             reset_addr,
  output logic                    vector_select_bit,
  output logic                    irq,
  input  wire logic [31:0]        s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [31:0]        s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready
);

  typedef enum logic [2:0] {
    ST_OPEN    = 3'b001,
    ST_WINDOW  = 3'b010,
    ST_TRAIL   = 3'b100
  } guard_t;

  guard_t                 guard_reg;
  logic [2:0]             cnt_reg;
  logic                   change_en_reg;
  logic [EVT_W-1:0]       stat_reg;
  logic [EVT_W-1:0]       mask_reg;
  logic [31:0]            awaddr_reg;
  logic [31:0]            wdata_reg;
  logic [3:0]             wstrb_reg;
  logic                   aw_have_reg;
  logic                   w_have_reg;
  logic [NUM_SRC-1:0]     present;
  logic [NUM_SRC-1:0]     pending;
  logic [4:0]             win_idx;
  logic                   win_any;
  logic                   wr_fire;
  logic                   ctrl_wr;
  logic                   sel_wr;
  logic                   blocked;
  logic [EVT_W-1:0]       evt;
  logic [31:0]            rd_next;
  logic [1:0]             rresp_next;

  // sources present in this variant
  assign present = LARGE_VARIANT ? {NUM_SRC{1'b1}} : NUM_SRC'((1 << SMALL_SRC) - 1); // R06

  // requests masked by variant, interrupt flag and block
  assign blocked = (guard_reg != ST_OPEN);
  assign pending = irq_request & present & {NUM_SRC{global_int_flag & ~blocked}};

  // lowest index wins
  always_comb begin
    win_idx = 5'h0;
    win_any = 1'b0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (pending[i]) begin
        win_idx = 5'(i); // R12
        win_any = 1'b1;
      end
    end
  end

  // reset address from fuse only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reset_addr <= RESET_VECTOR;
    end else begin
      reset_addr <= boot_reset_fuse ? RESET_VECTOR : BOOT_START; // R01 R08 R09
    end
  end

  // vector presentation to core
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vector_valid <= 1'b0;
      vector_addr  <= RESET_VECTOR;
    end else if (vector_valid && !vector_ack) begin
      vector_valid <= 1'b1;
    end else begin
      vector_valid <= win_any;
      // table position, then relocation
      vector_addr  <= (vector_select_bit ? BOOT_START : 16'h0000) + FIRST_VECTOR
                      + 16'(win_idx) * VECTOR_STRIDE; // R02 R03 R04 R05 R07 R09
    end
  end

  // axi write channel capture
  assign wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg   <= 1'b0;
      w_have_reg    <= 1'b0;
      awaddr_reg    <= 32'h0;
      wdata_reg     <= 32'h0;
      wstrb_reg     <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= !aw_have_reg && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_have_reg && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_have_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_have_reg <= 1'b0;
      end
    end
  end

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (awaddr_reg[31:2] <= VEC_OFFSET[31:2]) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  assign ctrl_wr = wr_fire && awaddr_reg[31:2] == CTRL_OFFSET[31:2] && wstrb_reg[0];
  assign sel_wr  = ctrl_wr && change_en_reg && !wdata_reg[CTRL_CE_BIT];

  // timed change guard
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      guard_reg     <= ST_OPEN;
      cnt_reg       <= 3'h0;
      change_en_reg <= 1'b0;
    end else begin
      case (guard_reg)
        ST_OPEN: begin
          if (ctrl_wr && wdata_reg[CTRL_CE_BIT]) begin
            guard_reg     <= ST_WINDOW; // R11
            change_en_reg <= 1'b1;
            cnt_reg       <= 3'h0;
          end
        end
        ST_WINDOW: begin
          cnt_reg <= cnt_reg + 3'h1;
          if (sel_wr) begin
            guard_reg     <= ST_TRAIL; // R10 R11
            change_en_reg <= 1'b0;
          end else if (cnt_reg + 3'h1 >= CHANGE_WINDOW) begin
            guard_reg     <= ST_OPEN; // R11
            change_en_reg <= 1'b0;
          end
        end
        ST_TRAIL: begin
          if (instr_retire) begin
            guard_reg <= ST_OPEN; // R11
          end
        end
        default: guard_reg <= ST_OPEN;
      endcase
    end
  end

  // select bit changes only inside window
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vector_select_bit <= 1'b0;
    end else if (guard_reg == ST_WINDOW && sel_wr) begin
      vector_select_bit <= wdata_reg[CTRL_SEL_BIT]; // R10
    end
  end

  // sticky events, set wins over clear
  assign evt[0] = (guard_reg == ST_WINDOW) && !sel_wr && (cnt_reg + 3'h1 >= CHANGE_WINDOW);
  assign evt[1] = (guard_reg == ST_WINDOW) && sel_wr;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_reg <= '0;
      mask_reg <= '0;
    end else begin
      if (wr_fire && awaddr_reg[31:2] == STAT_OFFSET[31:2] && wstrb_reg[0]) begin
        stat_reg <= (stat_reg & ~wdata_reg[EVT_W-1:0]) | evt;
      end else begin
        stat_reg <= stat_reg | evt;
      end
      if (wr_fire && awaddr_reg[31:2] == MASK_OFFSET[31:2] && wstrb_reg[0]) begin
        mask_reg <= wdata_reg[EVT_W-1:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(stat_reg & mask_reg);
    end
  end

  // read decode
  always_comb begin
    rd_next    = 32'h0;
    rresp_next = RESP_OKAY;
    case (s_axi_araddr[31:2])
      CTRL_OFFSET[31:2]: rd_next = {30'h0, vector_select_bit, change_en_reg};
      STAT_OFFSET[31:2]: rd_next = {30'h0, stat_reg};
      MASK_OFFSET[31:2]: rd_next = {30'h0, mask_reg};
      VEC_OFFSET[31:2]:  rd_next = {reset_addr, vector_addr};
      default:           rresp_next = RESP_SLVERR;
    endcase
  end

  // read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_next;
        s_axi_rresp  <= rresp_next;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // checks
  chk_reset_from_fuse: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 reset_addr == ($past(boot_reset_fuse) ? RESET_VECTOR : BOOT_START)) // R08
    else $error("reset address does not follow fuse");
  chk_fuse_free_reset: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(boot_reset_fuse) |-> reset_addr == RESET_VECTOR) // R01
    else $error("unprogrammed fuse but reset address not zero");
  chk_base_vector: assert property (@(posedge aclk) disable iff (!aresetn)
    (win_any && !(vector_valid && !vector_ack) && !vector_select_bit && pending[0])
      |=> vector_addr == FIRST_VECTOR) // R02
    else $error("request zero not at first vector");
  chk_timer_vector: assert property (@(posedge aclk) disable iff (!aresetn)
    (win_any && !(vector_valid && !vector_ack) && !vector_select_bit && win_idx == 5'd3)
      |=> vector_addr == 16'h0008) // R03
    else $error("timer two compare misplaced");
  chk_serial_vector: assert property (@(posedge aclk) disable iff (!aresetn)
    (win_any && !(vector_valid && !vector_ack) && !vector_select_bit && win_idx == 5'd11)
      |=> vector_addr == 16'h0018) // R04
    else $error("serial transfer vector misplaced");
  chk_store_vector: assert property (@(posedge aclk) disable iff (!aresetn)
    (win_any && !(vector_valid && !vector_ack) && !vector_select_bit && win_idx == 5'd20)
      |=> vector_addr == 16'h002a) // R05
    else $error("program store vector misplaced");
  chk_small_variant: assert property (@(posedge aclk) disable iff (!aresetn)
    !LARGE_VARIANT |-> !pending[NUM_SRC-1] && !pending[NUM_SRC-2]) // R06
    else $error("absent pin change source served");
  chk_relocated_vector: assert property (@(posedge aclk) disable iff (!aresetn)
    (win_any && !(vector_valid && !vector_ack) && vector_select_bit)
      |=> vector_addr >= BOOT_START + FIRST_VECTOR) // R07 R09
    else $error("relocated vector below boot start");
  chk_lowest_first: assert property (@(posedge aclk) disable iff (!aresetn)
    pending[0] |-> win_idx == 5'd0) // R12
    else $error("lowest request not chosen");
  sequence enable_written;
    guard_reg == ST_OPEN && ctrl_wr && wdata_reg[CTRL_CE_BIT];
  endsequence
  chk_block_window: assert property (@(posedge aclk) disable iff (!aresetn)
    enable_written |=> blocked [*4]) // R11
    else $error("interrupts not blocked during change window");
  chk_select_stable: assert property (@(posedge aclk) disable iff (!aresetn)
    (guard_reg != ST_WINDOW) |=> $stable(vector_select_bit)) // R10
    else $error("select bit changed outside window");
  chk_boot_reset: assert property (@(posedge aclk) disable iff (!aresetn)
    !boot_reset_fuse |=> reset_addr == BOOT_START) // R08
    else $error("programmed fuse but reset address not boot start");

  // guard timing and release
  chk_window_close: assert property (@(posedge aclk) disable iff (!aresetn)
    guard_reg == ST_WINDOW && !sel_wr && cnt_reg == CHANGE_WINDOW - 3'h1 |=> guard_reg == ST_OPEN) // R11
    else $error("change window did not close after four cycles");
  chk_trail_release: assert property (@(posedge aclk) disable iff (!aresetn)
    guard_reg == ST_TRAIL && instr_retire |=> guard_reg == ST_OPEN) // R11
    else $error("block not released after next instruction");
  chk_blocked_offer: assert property (@(posedge aclk) disable iff (!aresetn)
    blocked && !vector_valid |=> !vector_valid) // R11
    else $error("vector offered while blocked");
  chk_flag_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    !global_int_flag && !vector_valid |=> !vector_valid) // R11
    else $error("vector offered with interrupt flag clear");

  // select write lands with the written value
  sequence select_written;
    guard_reg == ST_WINDOW && sel_wr;
  endsequence
  chk_select_set: assert property (@(posedge aclk) disable iff (!aresetn)
    guard_reg == ST_WINDOW && sel_wr && wdata_reg[CTRL_SEL_BIT] |=> vector_select_bit) // R10
    else $error("select bit not set by timed write");
  chk_select_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    guard_reg == ST_WINDOW && sel_wr && !wdata_reg[CTRL_SEL_BIT] |=> !vector_select_bit) // R10
    else $error("select bit not cleared by timed write");
  chk_select_event: assert property (@(posedge aclk) disable iff (!aresetn)
    select_written |=> stat_reg[1]) // R10
    else $error("select change event lost");

  // vector link and priority
  chk_vector_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    vector_valid && !vector_ack |=> vector_valid && $stable(vector_addr))
    else $error("offered vector dropped before acknowledge");
  chk_no_lower_pending: assert property (@(posedge aclk) disable iff (!aresetn)
    win_any |-> (pending & ((NUM_SRC'(1) << win_idx) - NUM_SRC'(1))) == '0) // R12
    else $error("a lower pending request was skipped");

  // interrupt level and bus errors
  chk_irq_high: assert property (@(posedge aclk) disable iff (!aresetn)
    |(stat_reg & mask_reg) |=> irq)
    else $error("interrupt low with unmasked status");
  chk_irq_low: assert property (@(posedge aclk) disable iff (!aresetn)
    !(|(stat_reg & mask_reg)) |=> !irq)
    else $error("interrupt high without unmasked status");
  chk_read_error: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready && s_axi_araddr[31:2] > VEC_OFFSET[31:2]
      |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");

endmodule : interrupt_vector_mapper

//--- testbench/core_fetch_model.sv
`timescale 1ns/1ps
module core_fetch_model (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic vector_valid,
  input  wire logic slow,
  input  wire logic retire_go,
  output logic      vector_ack,
  output logic      instr_retire
);
  logic [1:0] wait_cnt;
  // takes an offered vector after one or three cycles
  always_ff @(posedge aclk) begin
    if (!aresetn || !vector_valid || vector_ack) begin
      wait_cnt   <= 2'h0;
      vector_ack <= 1'b0;
    end else begin
      wait_cnt   <= wait_cnt + 2'h1;
      vector_ack <= (wait_cnt == (slow ? 2'h2 : 2'h0));
    end
  end
  // one retired instruction per request
  always_ff @(posedge aclk) begin
    instr_retire <= aresetn && retire_go;
  end
endmodule : core_fetch_model

//--- testbench/interrupt_vector_mapper_tb_top.sv
`timescale 1ns/1ps
module interrupt_vector_mapper_tb_top
  import vector_map_pkg::*;
;
  localparam logic [15:0] BOOT = 16'h1c00;
  logic               aclk, aresetn, fuse, gif, ack, retire, retire_go, slow;
  logic [NUM_SRC-1:0] irq_request;
  logic               vector_valid, vector_select_bit, irq;
  logic [15:0]        vector_addr, reset_addr;
  logic [31:0]        awaddr, wdata, araddr, rdata, rdt;
  logic               awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [1:0]         bresp, rresp, rr;
  int                 n_errors, num_checks;

  // 100 MHz clock
  always #5 aclk = ~aclk;

  interrupt_vector_mapper #(.BOOT_START(BOOT)) dut_u (
    .aclk(aclk), .aresetn(aresetn), .boot_reset_fuse(fuse), .irq_request(irq_request),
    .global_int_flag(gif), .instr_retire(retire), .vector_ack(ack), .vector_valid(vector_valid),
    .vector_addr(vector_addr), .reset_addr(reset_addr), .vector_select_bit(vector_select_bit), .irq(irq),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));

  core_fetch_model core_u (.aclk(aclk), .aresetn(aresetn), .vector_valid(vector_valid), .slow(slow),
    .retire_go(retire_go), .vector_ack(ack), .instr_retire(retire));

  task automatic ck(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : ck

  task automatic wr(input logic [31:0] addr, input logic [31:0] data);
    int k;
    awaddr  <= addr;
    wdata   <= data;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    k = 0;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      k++;
    end while (k < 30 && bvalid !== 1'b1);
    rr = bresp;
    ck(bvalid, 1'b1);
    if (bvalid !== 1'b1) results();
  endtask : wr

  task automatic rd(input logic [31:0] addr);
    int k;
    araddr  <= addr;
    arvalid <= 1'b1;
    k = 0;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      k++;
    end while (k < 30 && rvalid !== 1'b1);
    rdt = rdata;
    rr  = rresp;
    ck(rvalid, 1'b1);
    if (rvalid !== 1'b1) results();
  endtask : rd

  // raise requests, expect one vector, then let the core take it
  task automatic srv(input logic [NUM_SRC-1:0] req, input logic [15:0] exp);
    int k;
    irq_request <= req;
    retire_go   <= 1'b1;
    k = 0;
    do begin
      @(posedge aclk);
      retire_go <= 1'b0;
      k++;
    end while (k < 30 && vector_valid !== 1'b1);
    ck(vector_valid, 1'b1);
    if (vector_valid !== 1'b1) results();
    ck(vector_addr, exp);
    irq_request <= '0;
    for (k = 0; k < 30 && vector_valid !== 1'b0; k++) @(posedge aclk);
    ck(vector_valid, 1'b0);
    if (vector_valid !== 1'b0) results();
  endtask : srv

  task automatic results;
    if (n_errors == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results

  // main sequence
  initial begin
    aclk = 1'b0;
    {awvalid, wvalid, arvalid, slow, retire_go, aresetn} = '0;
    {bready, rready, fuse, gif} = '1;
    {awaddr, wdata, araddr, irq_request, n_errors, num_checks} = '0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    ck(reset_addr, 16'h0000);
    for (int i = 0; i < NUM_SRC; i++) srv(24'h1 << i, 16'h0002 + 16'(2 * i));
    slow <= 1'b1;
    srv(24'h28, 16'h0008);
    slow <= 1'b0;
    rd(32'h0000_0010);
    ck(rr, RESP_SLVERR);
    ck(rdt, 32'h0);
    // change enable alone: blocked, then released after the window
    wr(CTRL_OFFSET, 32'h1);
    irq_request <= 24'h1;
    repeat (2) @(posedge aclk);
    ck(vector_valid, 1'b0);
    srv(24'h1, 16'h0002);
    rd(STAT_OFFSET);
    ck(rdt[1:0], 2'h1);
    ck(irq, 1'b0);
    wr(MASK_OFFSET, 32'h3);
    repeat (2) @(posedge aclk);
    ck(irq, 1'b1);
    // timed select change, blocked until the next instruction
    wr(CTRL_OFFSET, 32'h1);
    wr(CTRL_OFFSET, 32'h2);
    ck(rr, RESP_OKAY);
    irq_request <= 24'h1;
    repeat (6) @(posedge aclk);
    ck(vector_valid, 1'b0);
    ck(vector_select_bit, 1'b1);
    srv(24'h1, BOOT + 16'h0002);
    rd(STAT_OFFSET);
    ck(rdt[1:0], 2'h3);
    wr(STAT_OFFSET, 32'h3);
    repeat (2) @(posedge aclk);
    ck(irq, 1'b0);
    // programmed fuse with both select values
    fuse <= 1'b0;
    repeat (2) @(posedge aclk);
    ck(reset_addr, BOOT);
    srv(24'h2, BOOT + 16'h0004);
    wr(CTRL_OFFSET, 32'h1);
    wr(CTRL_OFFSET, 32'h0);
    srv(24'h4, 16'h0006);
    rd(VEC_OFFSET);
    ck(rdt[31:16], BOOT);
    results();
  end
endmodule : interrupt_vector_mapper_tb_top
